// *** design/rbs_startup.sv ***
/*
 holds the startup sequencer: strap capture, lock wait, core reset output,
 start of execution and the pll control register on a plain port.
 assumes straps and the reset pin are asynchronous to clk_in, and that
 a reference enable pulse marks each reference clock period.
*/
// What the block, the board and software do at startup
// [R01] ratio straps decode 3:1, 16:1, 8:1, reserved
// [R02] ratio straps only set the startup frequency
// [R03] software rewrites pll mult/div after reset
// [R04] core reset is driven out on a pin
// [R05] wait 4096 reference cycles after reset release
// [R06] then fetch starts at the reset vector
// [R07] board holds reset low during power-up
// [R08] boot straps decode slave, master, eprom, reserved
// [R09] board pulses or holds test clock low
// [R10] test reset low resets the test machine
// [R11] board keeps boot straps valid through reset
// [R12] core reset held until lock wait ends
// [R13] straps sampled only while reset asserted
`timescale 1ns/1ps
module rbs_startup
   import rbs_pkg::*;
#(
   parameter int unsigned LOCK_WAIT = LOCK_WAIT_REFCK
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ref_tick_in,
   // pins from the board
   input  wire logic        reset_pin_n_in,
   input  wire logic [1:0]  core_ratio_select_in,
   input  wire logic [1:0]  boot_source_select_in,
   input  wire logic        test_reset_n_in,
   // pins to the board
   output logic             core_reset_output_n_out,
   // core side
   output logic             core_run_out,
   output logic             fetch_start_out,
   output logic [31:0]      fetch_addr_out,
   output rbs_cfg_t         cfg_out,
   output rbs_pll_t         pll_out,
   output logic             test_sm_reset_out,
   // register port
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [31:0]      reg_rdata_out
);

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [1:0] rst_sync;
   logic [1:0] trst_sync;
   logic [1:0] ratio_s1, ratio_s2;
   logic [1:0] boot_s1, boot_s2;

   // two flops each; only the second stage is read
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rst_sync  <= 2'h0;
         trst_sync <= 2'h0;
         ratio_s1  <= 2'h0;
         ratio_s2  <= 2'h0;
         boot_s1   <= 2'h0;
         boot_s2   <= 2'h0;
      end else begin
         rst_sync  <= {rst_sync[0], reset_pin_n_in};
         trst_sync <= {trst_sync[0], test_reset_n_in};
         ratio_s1  <= core_ratio_select_in;
         ratio_s2  <= ratio_s1;
         boot_s1   <= boot_source_select_in;
         boot_s2   <= boot_s1;
      end
   end

   logic pin_rst;
   assign pin_rst = ~rst_sync[1];

   // ==========================================================
   // sequencer
   // ==========================================================
   typedef enum logic [1:0] {
      ST_RESET,
      ST_LOCK,
      ST_RUN
   } rbs_state_t;

   rbs_state_t             state, next_state;
   logic [LOCK_CNT_W-1:0]  lock_cnt;
   logic                   lock_done;

   assign lock_done = ref_tick_in &&
      (lock_cnt == LOCK_CNT_W'(LOCK_WAIT - 1));

   // next-state choice; pin reset always returns to the start
   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: begin
            if (!pin_rst) begin
               next_state = ST_LOCK;
            end
         end
         ST_LOCK: begin
            if (pin_rst) begin
               next_state = ST_RESET;
            end else if (lock_done) begin
               next_state = ST_RUN;           // [R05]
            end
         end
         ST_RUN: begin
            if (pin_rst) begin
               next_state = ST_RESET;
            end
         end
         default: next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // counts reference periods, not fast clocks, during the lock wait
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lock_cnt <= '0;
      end else if (state != ST_LOCK) begin
         lock_cnt <= '0;
      end else if (ref_tick_in) begin
         lock_cnt <= lock_cnt + LOCK_CNT_W'(1);  // [R05]
      end
   end

   // ==========================================================
   // strap capture
   // ==========================================================
   // sampled only in reset so later pin wiggles cannot retune the core
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg_out <= '{ratio: RATIO_VAL_3, ratio_bad: 1'b0,
                      boot: BOOT_SPI_SLAVE};
      end else if (state == ST_RESET) begin   // [R13]
         case (ratio_s2)                        // [R01]
            RATIO_CODE_3: begin
               cfg_out.ratio     <= RATIO_VAL_3;
               cfg_out.ratio_bad <= 1'b0;
            end
            RATIO_CODE_16: begin
               cfg_out.ratio     <= RATIO_VAL_16;
               cfg_out.ratio_bad <= 1'b0;
            end
            RATIO_CODE_8: begin
               cfg_out.ratio     <= RATIO_VAL_8;
               cfg_out.ratio_bad <= 1'b0;
            end
            default: begin
               cfg_out.ratio     <= RATIO_VAL_NONE;
               cfg_out.ratio_bad <= 1'b1;
            end
         endcase
         case (boot_s2)                         // [R08] [R11]
            BOOT_CODE_SLV:   cfg_out.boot <= BOOT_SPI_SLAVE;
            BOOT_CODE_MST:   cfg_out.boot <= BOOT_SPI_MASTER;
            BOOT_CODE_EPROM: cfg_out.boot <= BOOT_PAR_EPROM;
            default:         cfg_out.boot <= BOOT_RESERVED;
         endcase
      end
   end

   // ==========================================================
   // pll control register
   // ==========================================================
   logic wr_pll;
   assign wr_pll = reg_wr_in && (reg_addr_in == REG_PLL_CTRL);

   // strap ratio seeds it in reset; software owns it once running
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pll_out <= '0;
      end else if (state == ST_RESET) begin
         pll_out.mult  <= {3'h0, cfg_out.ratio};  // [R02]
         pll_out.div   <= 8'h01;
         pll_out.valid <= 1'b0;
      end else if (wr_pll && state == ST_RUN) begin
         pll_out.mult  <= reg_wdata_in[MULT_LSB +: 8];  // [R03]
         pll_out.div   <= reg_wdata_in[DIV_LSB +: 8];
         pll_out.valid <= 1'b1;
      end else begin
         pll_out.valid <= 1'b0;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   // core reset and run flip together at the end of the wait
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         core_reset_output_n_out <= 1'b0;
         core_run_out            <= 1'b0;
         fetch_start_out         <= 1'b0;
         fetch_addr_out          <= '0;
      end else begin
         core_reset_output_n_out <= (next_state == ST_RUN);  // [R04] [R12]
         core_run_out            <= (next_state == ST_RUN);
         fetch_start_out <= (state == ST_LOCK) && (next_state == ST_RUN);
         if ((state == ST_LOCK) && (next_state == ST_RUN)) begin
            fetch_addr_out <= RESET_VECTOR;                  // [R06]
         end
      end
   end

   // test machine held in reset while its pin is low
   assign test_sm_reset_out = ~trst_sync[1];  // [R10]

   // read data one cycle after the strobe, zero when idle or unmapped
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            REG_PLL_CTRL: reg_rdata_out <= {16'h0, pll_out.div,
                                            pll_out.mult};
            REG_STATUS:   reg_rdata_out <= {23'h0, core_run_out,
                                            cfg_out.ratio_bad,
                                            cfg_out.ratio,
                                            cfg_out.boot};
            REG_VECTOR:   reg_rdata_out <= RESET_VECTOR;
            default:      reg_rdata_out <= '0;
         endcase
      end else begin
         reg_rdata_out <= '0;
      end
   end

endmodule

// *** design/rbs_pkg.sv ***
/*
 holds constants and carrier types for the reset, boot and clock startup
 sequencer. assumes a single 200 MHz clock domain.
*/
package rbs_pkg;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int unsigned CLK_PERIOD_PS   = 5000;
   localparam int unsigned LOCK_WAIT_REFCK = 4096;  // reference cycles
   localparam int unsigned LOCK_CNT_W      = 13;

   // ==========================================================
   // strap encodings
   // ==========================================================
   localparam logic [1:0] RATIO_CODE_3    = 2'h0;
   localparam logic [1:0] RATIO_CODE_16   = 2'h1;
   localparam logic [1:0] RATIO_CODE_8    = 2'h2;
   localparam logic [1:0] BOOT_CODE_SLV   = 2'h0;
   localparam logic [1:0] BOOT_CODE_MST   = 2'h1;
   localparam logic [1:0] BOOT_CODE_EPROM = 2'h2;

   localparam logic [4:0] RATIO_VAL_3     = 5'h03;
   localparam logic [4:0] RATIO_VAL_16    = 5'h10;
   localparam logic [4:0] RATIO_VAL_8     = 5'h08;
   localparam logic [4:0] RATIO_VAL_NONE  = 5'h00;

   // ==========================================================
   // register port: offsets and layout
   // ==========================================================
   localparam logic [3:0] REG_PLL_CTRL    = 4'h0;  // power_pll_control
   localparam logic [3:0] REG_STATUS      = 4'h4;
   localparam logic [3:0] REG_VECTOR      = 4'h8;
   localparam int unsigned MULT_LSB       = 0;
   localparam int unsigned DIV_LSB        = 8;
   localparam logic [31:0] PLL_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] RESET_VECTOR   = 32'h0008_0000;  // arbitrary

   // ==========================================================
   // types
   // ==========================================================
   typedef enum logic [1:0] {
      BOOT_SPI_SLAVE,
      BOOT_SPI_MASTER,
      BOOT_PAR_EPROM,
      BOOT_RESERVED
   } rbs_boot_t;

   typedef struct packed {
      logic [4:0] ratio;        // core:reference multiple, 0 reserved
      logic       ratio_bad;
      rbs_boot_t  boot;
   } rbs_cfg_t;

   typedef struct packed {
      logic [7:0] mult;
      logic [7:0] div;
      logic       valid;        // pulse when software rewrites
   } rbs_pll_t;

endpackage

// *** verif/rbs_startup_monitor.sv ***
/* checker for the startup sequencer.
 assumes it is bound onto rbs_startup. */
`timescale 1ns/1ps
module rbs_startup_monitor
   import rbs_pkg::*;
#(parameter int unsigned LOCK_WAIT = 4) (
   // watched ports
   input wire logic        clk_in, sys_rst_in, ref_tick_in,
   input wire logic        reset_pin_n_in, test_reset_n_in,
   input wire logic        reg_wr_in, reg_rd_in, core_run_out,
   input wire logic        core_reset_output_n_out, fetch_start_out,
   input wire logic        test_sm_reset_out,
   input wire logic [3:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in, reg_rdata_out, fetch_addr_out,
   input wire rbs_cfg_t    cfg_out,
   input wire rbs_pll_t    pll_out
);
   // ==========
   // ticks since pin release; sync slack is left to the bounds
   logic [15:0] ticks;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) ticks <= '0;
      else if (!reset_pin_n_in) ticks <= '0;
      else if (ref_tick_in && !core_run_out) ticks <= ticks + 16'h1;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_pin; core_reset_output_n_out == core_run_out; endproperty
   a_pin: assert property (p_pin) else $error("reset out bad");
   property p_start;
      $rose(core_run_out) |-> fetch_start_out
         && fetch_addr_out == RESET_VECTOR;
   endproperty
   a_start: assert property (p_start) else $error("no fetch");
   property p_pulse; fetch_start_out |-> $rose(core_run_out); endproperty
   a_pulse: assert property (p_pulse) else $error("stray fetch");
   property p_wait; $rose(core_run_out) |-> ticks >= LOCK_WAIT; endproperty
   a_wait: assert property (p_wait) else $error("lock too short");
   property p_bound; ticks >= LOCK_WAIT + 6 |-> core_run_out; endproperty
   a_bound: assert property (p_bound) else $error("lock too long");
   property p_hold;
      core_run_out && $past(core_run_out, 2) |-> $stable(cfg_out);
   endproperty
   a_hold: assert property (p_hold) else $error("strap leak");
   property p_dec;
      core_run_out |-> cfg_out.ratio_bad == (cfg_out.ratio == 5'h00)
         && cfg_out.ratio inside {5'h03, 5'h10, 5'h08, 5'h00};
   endproperty
   a_dec: assert property (p_dec) else $error("ratio bad");
   property p_pll;
      core_run_out && reg_wr_in && reg_addr_in == REG_PLL_CTRL |=>
         pll_out.valid && pll_out.mult == $past(reg_wdata_in[7:0])
         && pll_out.div == $past(reg_wdata_in[15:8]);
   endproperty
   a_pll: assert property (p_pll) else $error("pll write lost");
   property p_test; !test_reset_n_in [*3] |-> test_sm_reset_out; endproperty
   a_test: assert property (p_test) else $error("test reset");
   c_run: cover property ($rose(core_run_out));
   c_pll: cover property (pll_out.valid);
   c_tst: cover property ($fell(test_sm_reset_out));
endmodule
bind rbs_startup rbs_startup_monitor #(.LOCK_WAIT(LOCK_WAIT)) u_mon (.*);

// *** verif/rbs_board.sv ***
/* board model: reset source, straps, test reset, ticks.
 assumes the bench calls boot right after a clock edge. */
`timescale 1ns/1ps
module rbs_board (
   // bench clock
   input wire logic  clk_in,
   // pins to the device
   output logic       reset_pin_n_in = 1'b0,
   output logic       test_reset_n_in = 1'b0,
   output logic       ref_tick_in = 1'b0,
   output logic [1:0] core_ratio_select_in = 2'h0,
   output logic [1:0] boot_source_select_in = 2'h0
);
   // ==========
   int gap = 1; // 1 prompt, larger slow
   int k = 0;
   // test clock kept low from power-up; the block has no pin for it
   logic test_clock = 1'b0;
   // one tick every gap cycles
   always @(posedge clk_in) begin
      k <= (k + 1 >= gap) ? 0 : k + 1;
      ref_tick_in <= (k == 0);
   end
   // straps set as reset goes low and stay through it
   task automatic boot(input logic [1:0] r, b);
      reset_pin_n_in <= 1'b0;
      core_ratio_select_in <= r;
      boot_source_select_in <= b;
      repeat (4) @(posedge clk_in);
      reset_pin_n_in <= 1'b1;
   endtask
endmodule

// *** verif/tb_rbs_startup.sv ***
/* self-checking bench for rbs_startup.
 assumes the board model and the bound checker. */
`timescale 1ns/1ps
module tb_rbs_startup;
   import rbs_pkg::*;
   // ==========
   logic        clk_in = 0, sys_rst_in = 1, rd_d = 0;
   logic        reg_wr_in = 0, reg_rd_in = 0;
   logic        reset_pin_n_in, test_reset_n_in, ref_tick_in;
   logic        core_reset_output_n_out, core_run_out, fetch_start_out;
   logic        test_sm_reset_out;
   logic [1:0]  core_ratio_select_in, boot_source_select_in;
   logic [3:0]  reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, fetch_addr_out;
   logic [31:0] seed = 32'd93724, exp_q[$];
   rbs_cfg_t    cfg_out;
   rbs_pll_t    pll_out;
   int          n_mismatch = 0, checked = 0;
   rbs_startup #(.LOCK_WAIT(4)) dut (.*);
   rbs_board brd (.*);
   initial forever #2.5 clk_in = ~clk_in;
   task automatic chk(string n, logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected status word from the straps
   function automatic logic [31:0] st(logic [1:0] r, b);
      logic [4:0] v;
      v = r == 0 ? 5'h03 : r == 1 ? 5'h10 : r == 2 ? 5'h08 : 5'h00;
      return {23'h0, 1'b1, r == 2'h3, v, b};
   endfunction
   // one-cycle strobes with a gap so no signal is set twice
   task automatic wr(logic [3:0] a, logic [31:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in) reg_wr_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      exp_q.push_back(e);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in) reg_rd_in <= 1'b0;
      @(posedge clk_in);
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clk_in) begin
      rd_d <= reg_rd_in;
      if (rd_d) chk("rdata", reg_rdata_out, exp_q.pop_front());
   end
   task automatic start(logic [1:0] r, b);
      int n = 0;
      brd.boot(r, b);
      while (core_run_out !== 1'b1 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      chk("rst_out", {31'h0, core_reset_output_n_out}, 32'h1);
      chk("wait", n >= 4 * brd.gap, 32'h1);
   endtask
   task automatic finish_test();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      logic [31:0] v;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      // every code, ticks from prompt to slow, noise after release
      for (int i = 0; i < 4; i++) begin
         brd.gap = i + 1;
         start(i[1:0], 2'(3 - i));
         v = rnd();
         brd.core_ratio_select_in <= v[1:0];
         brd.boot_source_select_in <= v[3:2];
         rd(REG_STATUS, st(i[1:0], 2'(3 - i)));
         v = rnd() & 32'h0000_ffff;
         wr(REG_PLL_CTRL, v);
         rd(REG_PLL_CTRL, v);
      end
      rd(REG_VECTOR, RESET_VECTOR);
      rd(4'hc, 32'h0);
      // in reset the write is refused and straps set the pll
      brd.reset_pin_n_in <= 1'b0;
      brd.core_ratio_select_in <= 2'h2;
      repeat (4) @(posedge clk_in);
      wr(REG_PLL_CTRL, rnd());
      rd(REG_PLL_CTRL, 32'h0000_0108);
      start(2'h2, 2'h0);
      brd.test_reset_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk("tsm", {31'h0, test_sm_reset_out}, 32'h0);
      brd.test_reset_n_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk("tsm", {31'h0, test_sm_reset_out}, 32'h1);
      finish_test();
   end
endmodule
